// ==== shared/isp_pkg.sv ====
// Constants and state codes for the shared SRAM port.
// Assumes one 200 MHz system clock; private bus periods are built from it.
package isp_pkg;
	// Clock and private bus period timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int PB_PERIOD_NS = 50;
	localparam int PB_DIV = (PB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] DIV_LAST = 4'(PB_DIV - 1);
	localparam logic [3:0] DIV_HALF = 4'(PB_DIV / 2 - 1);
	// Private bus period indices inside one byte cycle
	localparam logic [1:0] PER_FIRST = 2'h0;
	localparam logic [1:0] RD_LAST = 2'h1;
	localparam logic [1:0] WR_LAST = 2'h2;
	localparam logic [1:0] WE_ON_PER = 2'h0;
	localparam logic [1:0] WE_OFF_PER = 2'h2;
	localparam logic [1:0] PER_STEP = 2'h1;
	// Address layout
	localparam int ADDR_W = 16;
	localparam int WORD_W = 15;
	localparam int PA_LO_W = 10;
	localparam int PA_HI_W = 6;
	localparam logic [14:0] WORD_INC = 15'h0001;
	localparam logic [1:0] MASK_NONE = 2'h0;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RD = 4'h2,
		ST_WR = 4'h4,
		ST_EXT = 4'h8
	} isp_state_t;

	typedef enum logic [2:0] {
		JOB_FILL = 3'h1,
		JOB_PREF = 3'h2,
		JOB_DRAIN = 3'h4
	} isp_job_t;
endpackage

// ==== design/isp_tick_gen.sv ====
// Divider making 50 ns private bus period enables from the system clock.
// Assumes i_clk at the rate given in the package.
`timescale 1ns/10ps
module isp_tick_gen
	import isp_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_sys_rst, // Async reset, active high
	output logic o_rise, // Pulse: start of a private bus period
	output logic o_fall // Pulse: middle of a private bus period
);
	logic [3:0] cnt;
	wire at_last = (cnt == DIV_LAST);
	wire at_half = (cnt == DIV_HALF);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cnt <= 4'h0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end
		else
		begin
			cnt <= at_last ? 4'h0 : 4'(cnt + 4'h1);
			o_rise <= at_last;
			o_fall <= at_half;
		end
	end
endmodule

// ==== design/isp_shared_sram_port.sv ====
// Shared SRAM access path: ISA memory window onto an 8-bit private bus SRAM.
// Assumes ISA inputs synchronous to i_clk and an external window decoder.
// Function
// - Start on select, refresh off, read/write; ignore AEN
// - Post ISA writes in holding register, drain later
// - Holding register busy: stall new write via IOCHRDY
// - ISA read miss requests private bus, stalls until fill done
// - Granted read enables address buffer, compares address
// - Prefetch miss: stall and read two SRAM bytes
// - Prefetch hit: drive word, release IOCHRDY
// - Hold data until read ends, then prefetch
// - Prefetches step up by one word
// - Any other private bus activity invalidates prefetch
// - No byte-high-enable seen since reset: 8-bit only
// - SRAM read: two periods, strobe first, sample end
// - SRAM write: three periods, address and data held
// - Write strobe from first to third period middle
// - Period timing derived as 50 ns periods
`timescale 1ns/10ps
module isp_shared_sram_port
	import isp_pkg::*;
(
	input wire logic i_clk, // 200 MHz system clock
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic [15:0] i_sa, // System address SA0-15
	input wire logic i_refresh_n, // Refresh, active low
	input wire logic i_memr_n, // Memory read, active low
	input wire logic i_memw_n, // Memory write, active low
	input wire logic i_shared_mem_select_in_n, // SRAM window decode, active low
	input wire logic i_sbhe_n, // System byte high enable, active low
	input wire logic [15:0] i_sd, // System data in
	output logic [15:0] o_sd, // System data out
	output logic o_sd_oe_lo, // Drive SD0-7
	output logic o_sd_oe_hi, // Drive SD8-15
	output logic o_iochrdy_oe, // Pull IOCHRDY low while high
	output logic o_addr_buffer_out_en_n, // Upper address buffer enable, low
	output logic [9:0] o_pra_lo, // Private address bits 0-9
	output logic [5:0] o_pra_hi, // Private address bits 10-15
	output logic o_pra_hi_oe, // Drive private address bits 10-15
	input wire logic [7:0] i_private_data_bus, // Private data in
	output logic [7:0] o_private_data_bus, // Private data out
	output logic o_private_data_bus_oe, // Drive private data
	output logic o_sram_read_strobe_n, // SRAM output enable, low
	output logic o_sram_write_strobe_n, // SRAM write enable, low
	input wire logic i_net_req, // Network side wants private bus
	output logic o_net_gnt, // Network side owns private bus
	input wire logic i_prom_req, // PROM access wants private bus
	output logic o_prom_gnt // PROM access owns private bus
);
	// Addressed SRAM bytes of an ISA cycle: {high, low}
	function automatic logic [1:0] byte_mask(input logic wide, input logic a0,
		input logic bhe_n);
		byte_mask = wide ? {!bhe_n, !a0} : {a0, !a0};
	endfunction

	isp_state_t st, next_st;
	isp_job_t job, next_job;
	logic [WORD_W-1:0] job_word, next_word;
	logic bsel, next_bsel;
	logic [1:0] per, next_per;
	logic ext_prom, next_ext_prom;
	logic tick_rise, tick_fall;
	logic wide, rd_q, wr_taken;
	logic pf_valid, pf_req;
	logic [WORD_W-1:0] pf_addr, hold_word;
	logic [15:0] pf_data, hold_data;
	logic [1:0] hold_be;

	isp_tick_gen u_tick (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.o_rise(tick_rise),
		.o_fall(tick_fall)
	);

	// ISA cycle decode; AEN plays no part in memory cycles
	wire rd_cyc = !i_shared_mem_select_in_n && i_refresh_n && !i_memr_n;
	wire wr_cyc = !i_shared_mem_select_in_n && i_refresh_n && !i_memw_n;
	wire [WORD_W-1:0] isa_word = i_sa[ADDR_W-1:1];
	wire [1:0] isa_mask = byte_mask(wide, i_sa[0], i_sbhe_n);
	wire hit = pf_valid && (pf_addr == isa_word);
	wire hold_full = (hold_be != MASK_NONE);
	wire take = wr_cyc && !wr_taken && !hold_full;
	wire serve = rd_cyc && hit;
	wire fill_need = rd_cyc && !hit;
	wire ext_req = ext_prom ? i_prom_req : i_net_req;
	wire rd_byte_end = (st == ST_RD) && tick_rise && (per == RD_LAST);
	wire rd_done = rd_byte_end && bsel;
	wire wr_byte_end = (st == ST_WR) && tick_rise && (per == WR_LAST);
	wire start_job = (st == ST_IDLE) && (next_st != ST_IDLE);
	wire pb_busy = (next_st == ST_RD) || (next_st == ST_WR);
	wire [ADDR_W-1:0] next_pa = pb_busy ? {next_word, next_bsel} : i_sa;
	wire read_owned = (next_st == ST_IDLE) || ((next_st == ST_RD) && (next_job == JOB_FILL));
	wire next_stall = fill_need || (wr_cyc && !wr_taken && hold_full);
	wire [7:0] sd_lo = isa_mask[0] ? pf_data[7:0] : pf_data[15:8];

	// Private bus arbiter and byte cycle sequencer
	always_comb
	begin
		next_st = st;
		next_job = job;
		next_word = job_word;
		next_bsel = bsel;
		next_per = per;
		next_ext_prom = ext_prom;
		unique case (st)
			ST_IDLE:
			begin
				if (tick_rise)
				begin
					next_per = PER_FIRST;
					// One owner at a time, picked only between cycles
					if (hold_full)
					begin
						next_st = ST_WR;
						next_job = JOB_DRAIN;
						next_word = hold_word;
						next_bsel = !hold_be[0];
					end
					else if (fill_need)
					begin
						next_st = ST_RD;
						next_job = JOB_FILL;
						next_word = isa_word;
						next_bsel = 1'b0;
					end
					else if (i_net_req || i_prom_req)
					begin
						next_st = ST_EXT;
						next_ext_prom = !i_net_req;
					end
					else if (pf_req && !rd_cyc && !wr_cyc)
					begin
						next_st = ST_RD;
						next_job = JOB_PREF;
						next_word = WORD_W'(pf_addr + WORD_INC);
						next_bsel = 1'b0;
					end
				end
			end
			ST_RD:
			begin
				if (tick_rise)
				begin
					next_per = (per == RD_LAST) ? PER_FIRST : 2'(per + PER_STEP);
					if (rd_byte_end)
					begin
						next_bsel = 1'b1;
						next_st = bsel ? ST_IDLE : ST_RD;
					end
				end
			end
			ST_WR:
			begin
				if (tick_rise)
				begin
					next_per = (per == WR_LAST) ? PER_FIRST : 2'(per + PER_STEP);
					if (wr_byte_end)
					begin
						next_bsel = 1'b1;
						next_st = (!bsel && hold_be[1]) ? ST_WR : ST_IDLE;
					end
				end
			end
			ST_EXT:
			begin
				if (tick_rise && !ext_req)
					next_st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st <= ST_IDLE;
			job <= JOB_PREF;
			job_word <= '0;
			bsel <= 1'b0;
			per <= PER_FIRST;
			ext_prom <= 1'b0;
		end
		else
		begin
			st <= next_st;
			job <= next_job;
			job_word <= next_word;
			bsel <= next_bsel;
			per <= next_per;
			ext_prom <= next_ext_prom;
		end
	end

	// Prefetch buffer, posted write holding register and bus width mode
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wide <= 1'b0;
			rd_q <= 1'b0;
			wr_taken <= 1'b0;
			pf_valid <= 1'b0;
			pf_req <= 1'b0;
			pf_addr <= '0;
			pf_data <= '0;
			hold_word <= '0;
			hold_data <= '0;
			hold_be <= MASK_NONE;
		end
		else
		begin
			wide <= wide || !i_sbhe_n;
			rd_q <= rd_cyc;
			wr_taken <= wr_cyc && (wr_taken || take);
			if (rd_byte_end)
				pf_data[bsel*8 +: 8] <= i_private_data_bus;
			if (rd_done)
				pf_addr <= job_word;
			if (take || start_job)
				pf_valid <= 1'b0;
			else if (rd_done)
				pf_valid <= 1'b1;
			if (rd_q && !rd_cyc)
				pf_req <= 1'b1;
			else if (take || (start_job && next_job == JOB_PREF))
				pf_req <= 1'b0;
			if (take)
			begin
				hold_word <= isa_word;
				hold_data <= wide ? i_sd : {i_sd[7:0], i_sd[7:0]};
				hold_be <= isa_mask;
			end
			else if (wr_byte_end)
				hold_be[bsel] <= 1'b0;
		end
	end

	// Registered pin drive
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_sd <= '0;
			o_sd_oe_lo <= 1'b0;
			o_sd_oe_hi <= 1'b0;
			o_iochrdy_oe <= 1'b0;
			o_addr_buffer_out_en_n <= 1'b1;
			o_pra_lo <= '0;
			o_pra_hi <= '0;
			o_pra_hi_oe <= 1'b0;
			o_private_data_bus <= '0;
			o_private_data_bus_oe <= 1'b0;
			o_sram_read_strobe_n <= 1'b1;
			o_sram_write_strobe_n <= 1'b1;
			o_net_gnt <= 1'b0;
			o_prom_gnt <= 1'b0;
		end
		else
		begin
			o_sd <= {pf_data[15:8], sd_lo};
			o_sd_oe_lo <= serve && (isa_mask[0] || !wide);
			o_sd_oe_hi <= serve && wide && isa_mask[1];
			o_iochrdy_oe <= next_stall;
			o_addr_buffer_out_en_n <= !(rd_cyc && read_owned);
			o_pra_lo <= next_pa[PA_LO_W-1:0];
			o_pra_hi <= next_pa[ADDR_W-1:PA_LO_W];
			o_pra_hi_oe <= pb_busy && (next_job != JOB_FILL);
			o_private_data_bus <= next_bsel ? hold_data[15:8] : hold_data[7:0];
			o_private_data_bus_oe <= (next_st == ST_WR);
			o_sram_read_strobe_n <= (next_st != ST_RD);
			if (tick_fall && st == ST_WR && per == WE_ON_PER)
				o_sram_write_strobe_n <= 1'b0;
			else if (tick_fall && st == ST_WR && per == WE_OFF_PER)
				o_sram_write_strobe_n <= 1'b1;
			o_net_gnt <= (next_st == ST_EXT) && !next_ext_prom;
			o_prom_gnt <= (next_st == ST_EXT) && next_ext_prom;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	rd_strobe_len_a: assert property ($fell(o_sram_read_strobe_n) |->
		!o_sram_read_strobe_n [*8] ##12 !o_sram_read_strobe_n)
		else $error("read strobe shorter than two periods");
	we_width_a: assert property ($fell(o_sram_write_strobe_n) |->
		!o_sram_write_strobe_n [*8] ##13 $rose(o_sram_write_strobe_n))
		else $error("write strobe not twenty cycles wide");
	we_data_held_a: assert property (!o_sram_write_strobe_n |->
		o_private_data_bus_oe && o_sram_read_strobe_n && $stable(o_pra_lo))
		else $error("write strobe without stable address and data");
	write_stall_a: assert property ((wr_cyc && !wr_taken && hold_full) |=>
		o_iochrdy_oe)
		else $error("write not stalled while holding register full");
	hit_serve_a: assert property (serve |=> !o_iochrdy_oe &&
		(o_sd_oe_lo || o_sd_oe_hi))
		else $error("prefetch hit not served");
	miss_stall_a: assert property (fill_need |=> o_iochrdy_oe)
		else $error("prefetch miss not stalled");
	narrow_mode_a: assert property (!wide |-> !o_sd_oe_hi)
		else $error("high lane driven in 8-bit mode");
	ext_invalid_a: assert property ((o_net_gnt || o_prom_gnt) |-> !pf_valid)
		else $error("prefetch valid during other bus owner");
	one_owner_a: assert property ((o_net_gnt || o_prom_gnt) |->
		o_sram_read_strobe_n && !o_private_data_bus_oe && !(o_net_gnt && o_prom_gnt))
		else $error("private bus shared by two owners");
	prefetch_step_a: assert property ((rd_done && job == JOB_PREF) |=>
		pf_addr == WORD_W'($past(pf_addr) + WORD_INC))
		else $error("prefetch address not next word");

	fill_c: cover property (fill_need ##[1:100] serve);
	stall_c: cover property (wr_cyc && hold_full && !wr_taken);
	ext_c: cover property ($rose(o_net_gnt));
	pref_c: cover property (rd_done && job == JOB_PREF);
endmodule

// ==== test/isp_board_model.sv ====
// Board model: SRAM window decoder and byte-wide SRAM on the private bus.
// Assumes the port owns the private bus; unwritten SRAM holds a fixed pattern.
`timescale 1ns/10ps
module isp_board_model
(
	input wire logic [15:0] i_sa, // System address
	input wire logic i_win_en, // Address lies in the SRAM window
	input wire logic i_refresh_n, // Refresh, active low
	input wire logic i_addr_buffer_out_en_n, // Upper address buffer enable, low
	input wire logic [9:0] i_pra_lo, // Private address low bits
	input wire logic [5:0] i_pra_hi, // Private address high bits
	input wire logic i_pra_hi_oe, // Port drives high address bits
	input wire logic [7:0] i_data, // Private data from the port
	input wire logic i_data_oe, // Port drives private data
	input wire logic i_sram_read_strobe_n, // SRAM output enable, low
	input wire logic i_sram_write_strobe_n, // SRAM write enable, low
	output logic o_shared_mem_select_in_n, // Window decode, low
	output logic [7:0] o_data // SRAM read data
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	// Decode is gated by refresh so it stays stable
	assign o_shared_mem_select_in_n = !(i_win_en && i_refresh_n);
	assign addr[9:0] = i_pra_lo;
	// High bits come from the port or through the address buffer
	assign addr[15:10] = i_pra_hi_oe ? i_pra_hi : (!i_addr_buffer_out_en_n ? i_sa[15:10] : 6'h2a);
	// Chip select tied active; released lines show the inverse byte
	assign o_data = !i_sram_read_strobe_n ? mem[addr] : ~mem[addr];
	initial
		for (int k = 0; k < 65536; k++)
			mem[k] = 8'(k ^ (k >> 8));
	always @(posedge i_sram_write_strobe_n)
		if (i_data_oe)
			mem[addr] <= i_data;
endmodule

// ==== test/test_isp_shared_sram_port.sv ====
// Bench for the shared SRAM port: ISA master tasks, result queue, board model.
// Assumes the package and the board model are compiled first.
`timescale 1ns/10ps
module test_isp_shared_sram_port
	import isp_pkg::*;
;
	logic clk = 0, rst = 1, ref_n = 1, memr_n = 1, memw_n = 1, sbhe_n = 1;
	logic win = 1, net_req = 0, prom_req = 0, stall = 0, done = 0;
	logic [15:0] sa = 16'h0000, sd = 16'h0000, o_sd, b, d;
	logic sel_n, oe_lo, oe_hi, rdy_oe, abuf_n, hi_oe, pd_oe, rd_n, we_n, net_gnt, prom_gnt;
	logic [9:0] pra_lo;
	logic [5:0] pra_hi;
	logic [7:0] pd_out, board_d, sh [0:65535];
	logic [31:0] seed = 32'h4a32_4dc6;
	logic [17:0] q [$];
	logic [17:0] note;
	int failures = 0, compares = 0, rd_cnt = 0, we_cnt = 0;

	isp_shared_sram_port dut (.i_clk(clk), .i_sys_rst(rst), .i_sa(sa), .i_refresh_n(ref_n),
		.i_memr_n(memr_n), .i_memw_n(memw_n), .i_shared_mem_select_in_n(sel_n),
		.i_sbhe_n(sbhe_n), .i_sd(sd), .o_sd(o_sd), .o_sd_oe_lo(oe_lo), .o_sd_oe_hi(oe_hi),
		.o_iochrdy_oe(rdy_oe), .o_addr_buffer_out_en_n(abuf_n), .o_pra_lo(pra_lo),
		.o_pra_hi(pra_hi), .o_pra_hi_oe(hi_oe), .i_private_data_bus(pd_oe ? pd_out : board_d),
		.o_private_data_bus(pd_out), .o_private_data_bus_oe(pd_oe),
		.o_sram_read_strobe_n(rd_n), .o_sram_write_strobe_n(we_n), .i_net_req(net_req),
		.o_net_gnt(net_gnt), .i_prom_req(prom_req), .o_prom_gnt(prom_gnt));
	isp_board_model board (.i_sa(sa), .i_win_en(win), .i_refresh_n(ref_n),
		.i_addr_buffer_out_en_n(abuf_n), .i_pra_lo(pra_lo), .i_pra_hi(pra_hi),
		.i_pra_hi_oe(hi_oe), .i_data(pd_out), .i_data_oe(pd_oe), .i_sram_read_strobe_n(rd_n),
		.i_sram_write_strobe_n(we_n), .o_shared_mem_select_in_n(sel_n), .o_data(board_d));

	initial
		forever #2.5 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Read cycle; s[1] asks for a stall check, s[0] is the stall expected
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [1:0] s);
		int n;
		q.push_back({s, e});
		@(negedge clk);
		sa = a;
		memr_n = 0;
		for (n = 0; n < 400 && !(oe_lo && !rdy_oe); n++)
			@(negedge clk);
		repeat (2) @(negedge clk);
		memr_n = 1;
		@(negedge clk);
		check({15'h0, n == 400}, 16'h0000);
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic s);
		int n;
		@(negedge clk);
		sa = a;
		sd = v;
		memw_n = 0;
		repeat (2) @(negedge clk);
		for (n = 0; n < 400 && rdy_oe; n++)
			@(negedge clk);
		check({15'h0, n != 0}, {15'h0, s});
		@(negedge clk);
		memw_n = 1;
	endtask

	task automatic ext(input logic p);
		int n;
		@(negedge clk);
		net_req = !p;
		prom_req = p;
		for (n = 0; n < 400 && !(p ? prom_gnt : net_gnt); n++)
			@(negedge clk);
		check({14'h0, net_gnt, prom_gnt}, {14'h0, !p, p});
		net_req = 0;
		prom_req = 0;
		repeat (30) @(negedge clk);
	endtask

	// Takes the oldest note when read data appears and compares it
	always @(negedge clk)
	begin
		if (memr_n)
		begin
			stall = 0;
			done = 0;
		end
		else if (rdy_oe)
			stall = 1;
		else if (oe_lo && !done && q.size() > 0)
		begin
			note = q.pop_front();
			done = 1;
			check(sbhe_n ? {8'h00, o_sd[7:0]} : o_sd, note[15:0]);
			check({15'h0, oe_hi}, {15'h0, !sbhe_n});
			if (note[17])
				check({15'h0, stall}, {15'h0, note[16]});
		end
		if (!we_n)
		begin
			we_cnt++;
			check({15'h0, pd_oe}, 16'h0001);
		end
		else if (we_cnt != 0)
		begin
			check(16'(we_cnt), 16'(2 * PB_DIV));
			we_cnt = 0;
		end
		if (!rd_n)
			rd_cnt++;
		else if (rd_cnt != 0)
		begin
			check(16'(rd_cnt), 16'(4 * PB_DIV));
			rd_cnt = 0;
		end
	end

	initial
	begin
		#(5 * 20000);
		failures++;
		stop_test();
	end

	initial
	begin
		for (int k = 0; k < 65536; k++)
			sh[k] = 8'(k ^ (k >> 8));
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 0;
		repeat (5) @(negedge clk);
		win = 0;
		memr_n = 0;
		repeat (30) @(negedge clk);
		check({14'h0, oe_lo, rdy_oe}, 16'h0000);
		memr_n = 1;
		win = 1;
		// Narrow phase: SBHE held high, port stays 8-bit
		seed = xs(seed);
		b = {seed[15:4], 4'h0};
		d = seed[31:16];
		sh[b] = d[7:0];
		sh[b + 1] = d[15:8];
		wr(b, {8'h00, d[7:0]}, 0);
		wr(b + 1, {8'h00, d[15:8]}, 1);
		rd(b + 1, {8'h00, d[15:8]}, 2'b11);
		repeat (80) @(negedge clk);
		rd(b + 2, {8'h00, sh[b + 2]}, 2'b10);
		// Wide phase: SBHE driven low, port switches to 16-bit
		sbhe_n = 0;
		for (int i = 0; i < 6; i++)
		begin
			seed = xs(seed);
			b = {seed[15:4], 4'h0};
			d = seed[31:16];
			sh[b] = d[7:0];
			sh[b + 1] = d[15:8];
			wr(b, d, 0);
			rd(b, d, 2'b00);
			repeat (80) @(negedge clk);
			rd(b + 2, {sh[b + 3], sh[b + 2]}, 2'b10);
			repeat (80) @(negedge clk);
			ext(i[0]);
			rd(b + 4, {sh[b + 5], sh[b + 4]}, 2'b11);
		end
		check(16'(q.size()), 16'h0000);
		stop_test();
	end
endmodule
